// >>> common/prfc_pkg.sv
package prfc_pkg;

    // Bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int STRB_W = 4;

    // Register offsets
    localparam logic [ADDR_W-1:0] OFF_BANK_PORT_SEL = 12'h000;
    localparam logic [ADDR_W-1:0] OFF_TS_CMD_CTL = 12'h004;
    localparam logic [ADDR_W-1:0] OFF_CAPTURE_STATUS = 12'h008;
    localparam logic [ADDR_W-1:0] OFF_FILTER_MATCH = 12'h00C;
    localparam logic [ADDR_W-1:0] OFF_CF_ENABLES = 12'h164;
    localparam logic [ADDR_W-1:0] OFF_FILTER_CFG = 12'h168;
    localparam logic [ADDR_W-1:0] OFF_CAP_SECONDS = 12'h16C;
    localparam logic [ADDR_W-1:0] OFF_CAP_NANOS = 12'h170;
    localparam logic [ADDR_W-1:0] OFF_CAP_HEADER = 12'h174;
    localparam logic [ADDR_W-1:0] OFF_FILTERED_CNT = 12'h18C;

    // Bank and port routing
    localparam logic [2:0] PORT_BANK = 3'h1;
    localparam logic [1:0] THIS_PORT = 2'h0;

    // Reset values, version wildcard and counter ceiling
    localparam logic [15:0] CF_ENABLE_RST = 16'h000F;
    localparam logic [15:0] TYPE_FILTER_RST = 16'h0000;
    localparam logic [3:0] VERSION_MATCH_RST = 4'h2;
    localparam logic [7:0] DOMAIN_MATCH_RST = 8'h00;
    localparam logic [3:0] VERSION_ANY = 4'h0;
    localparam logic [31:0] COUNT_MAX = 32'hFFFF_FFFF;

    // Capture status and timestamp control fields
    localparam int POP_BIT = 8;
    localparam int TS_ENABLE_BIT = 0;

    // Capture buffer
    localparam int CAP_DEPTH = 4;
    localparam int CAP_IDX_W = 2;
    localparam int CAP_CNT_W = 3;

    // Source identity checksum
    localparam int SRC_ID_W = 80;
    localparam logic [11:0] CRC12_POLY = 12'h80F;
    localparam logic [11:0] CRC12_INIT = 12'h000;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [25:0] rsvdHigh;
        logic [1:0] portSel;
        logic rsvdLow;
        logic [2:0] bankSel;
    } prfc_bank_port_t;

    typedef struct packed {
        logic [12:0] rsvd;
        logic alternateFlagFilterEnable;
        logic domainFilterEnable;
        logic versionFilterEnable;
        logic [15:0] typeFilterMask;
    } prfc_filter_cfg_t;

    typedef struct packed {
        logic [19:0] rsvd;
        logic [7:0] domainMatch;
        logic [3:0] versionMatch;
    } prfc_filter_match_t;

    typedef struct packed {
        logic [11:0] sourceIdentityCrc;
        logic [3:0] capturedMessageType;
        logic [15:0] capturedSequenceNumber;
    } prfc_header_t;

    typedef struct packed {
        logic [31:0] captureSeconds;
        logic [29:0] captureNanoseconds;
        prfc_header_t header;
    } prfc_capture_t;

    typedef struct packed {
        logic valid;
        logic [3:0] messageType;
        logic [3:0] version;
        logic [7:0] domain;
        logic alternateFlag;
        logic [15:0] sequenceId;
        logic [SRC_ID_W-1:0] sourceIdentity;
        logic [31:0] ingressSeconds;
        logic [29:0] ingressNanoseconds;
    } prfc_rx_msg_t;

    typedef struct packed {
        logic valid;
        logic drop;
        logic rxError;
        logic correctionModify;
    } prfc_verdict_t;

endpackage : prfc_pkg

// >>> hw/prfc_capture_buffer.sv
`timescale 1ns/100ps
module prfc_capture_buffer (
    input logic clk,
    input logic rstn,
    input logic pushValid,
    output logic pushReady,
    input prfc_pkg::prfc_capture_t pushData,
    output logic popValid,
    input logic popReady,
    output prfc_pkg::prfc_capture_t popData,
    output logic [prfc_pkg::CAP_CNT_W-1:0] count
);
    prfc_pkg::prfc_capture_t mem_q [prfc_pkg::CAP_DEPTH];
    prfc_pkg::prfc_capture_t mem_d [prfc_pkg::CAP_DEPTH];
    logic [prfc_pkg::CAP_IDX_W-1:0] rdPtr_q, rdPtr_d, wrPtr_q, wrPtr_d;
    logic [prfc_pkg::CAP_CNT_W-1:0] count_q, count_d;
    logic doPush, doPop;

    assign pushReady = (count_q != prfc_pkg::CAP_CNT_W'(prfc_pkg::CAP_DEPTH));
    assign popValid = (count_q != '0);
    assign popData = mem_q[rdPtr_q];
    assign count = count_q;
    assign doPush = pushValid && pushReady;
    assign doPop = popValid && popReady;

    always_comb begin
        mem_d = mem_q;
        wrPtr_d = wrPtr_q;
        rdPtr_d = rdPtr_q;
        count_d = count_q;
        if (doPush) begin
            mem_d[wrPtr_q] = pushData;
            wrPtr_d = wrPtr_q + 1'b1;
        end
        if (doPop) begin
            rdPtr_d = rdPtr_q + 1'b1;
        end
        if (doPush && !doPop) begin
            count_d = count_q + 1'b1;
        end else if (doPop && !doPush) begin
            count_d = count_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < prfc_pkg::CAP_DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            mem_q <= mem_d;
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end
endmodule : prfc_capture_buffer

// >>> hw/prfc_rx_filter_capture.sv
// Overview of operation
// - Correct only types whose enable bit set
// - Drop types selected in type filter mask
// - Version filter enable drops mismatched versions unless version match is zero
// - Domain filter enable drops other domains
// - Alternate filter enable drops flagged messages
// - Buffer four captures of seconds, nanos, header
// - Captures valid only while count nonzero
// - Seconds word read-only, resets zero
// - Nanoseconds in low thirty bits only
// - Source identity CRC in header top bits
// - Message type copied into header field
// - Sequence number in header low bits
// - Port registers visible only in bank one
// - Port select routes port bank accesses
// - Filtered messages dropped, counted, flagged error
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/100ps
module prfc_rx_filter_capture (
    input logic core_clk,
    input logic resetn,
    input logic [prfc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [prfc_pkg::DATA_W-1:0] s_axi_wdata,
    input logic [prfc_pkg::STRB_W-1:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [prfc_pkg::ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [prfc_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input prfc_pkg::prfc_rx_msg_t rxMsg,
    output prfc_pkg::prfc_verdict_t rxVerdict
);
    // Reset release
    logic rstMeta_q, rstn;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rstMeta_q <= 1'b0;
            rstn <= 1'b0;
        end else begin
            rstMeta_q <= 1'b1;
            rstn <= rstMeta_q;
        end
    end

    function automatic logic [11:0] crc12(
        input logic [prfc_pkg::SRC_ID_W-1:0] data
    );
        logic [11:0] crc;
        logic fb;
        crc = prfc_pkg::CRC12_INIT;
        for (int i = prfc_pkg::SRC_ID_W - 1; i >= 0; i--) begin
            fb = crc[11] ^ data[i];
            crc = {crc[10:0], 1'b0};
            if (fb) begin
                crc = crc ^ prfc_pkg::CRC12_POLY;
            end
        end
        return crc;
    endfunction : crc12

    function automatic logic [31:0] mergeStrb(
        input logic [31:0] old,
        input logic [31:0] data,
        input logic [prfc_pkg::STRB_W-1:0] strb
    );
        logic [31:0] res;
        res = old;
        for (int b = 0; b < prfc_pkg::STRB_W; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        return res;
    endfunction : mergeStrb

    function automatic logic isPortReg(
        input logic [prfc_pkg::ADDR_W-1:0] addr
    );
        return addr == prfc_pkg::OFF_CF_ENABLES ||
            addr == prfc_pkg::OFF_FILTER_CFG ||
            addr == prfc_pkg::OFF_CAP_SECONDS ||
            addr == prfc_pkg::OFF_CAP_NANOS ||
            addr == prfc_pkg::OFF_CAP_HEADER ||
            addr == prfc_pkg::OFF_FILTERED_CNT;
    endfunction : isPortReg

    function automatic logic isOwnReg(
        input logic [prfc_pkg::ADDR_W-1:0] addr
    );
        return addr == prfc_pkg::OFF_BANK_PORT_SEL ||
            addr == prfc_pkg::OFF_TS_CMD_CTL ||
            addr == prfc_pkg::OFF_CAPTURE_STATUS ||
            addr == prfc_pkg::OFF_FILTER_MATCH;
    endfunction : isOwnReg

    // Register state
    prfc_pkg::prfc_bank_port_t bankPort_q, bankPort_d;
    prfc_pkg::prfc_filter_cfg_t filterCfg_q, filterCfg_d;
    prfc_pkg::prfc_filter_match_t filterMatch_q, filterMatch_d;
    logic [15:0] cfEnable_q, cfEnable_d;
    logic tsEnable_q, tsEnable_d;
    logic [31:0] filteredCnt_q, filteredCnt_d;

    // Bus state
    logic awReady_q, awReady_d, awHeld_q, awHeld_d;
    logic [prfc_pkg::ADDR_W-1:0] awAddr_q, awAddr_d;
    logic wReady_q, wReady_d, wHeld_q, wHeld_d;
    logic [31:0] wData_q, wData_d;
    logic [prfc_pkg::STRB_W-1:0] wStrb_q, wStrb_d;
    logic bValid_q, bValid_d, arReady_q, arReady_d, rValid_q, rValid_d;
    logic [1:0] bResp_q, bResp_d, rResp_q, rResp_d;
    logic [31:0] rData_q, rData_d;

    // Verdict state
    prfc_pkg::prfc_verdict_t verdict_q, verdict_d;

    // Capture buffer wiring
    prfc_pkg::prfc_capture_t capIn, capHead;
    logic capPush, capPop;
    logic [prfc_pkg::CAP_CNT_W-1:0] capCount;

    logic doWrite, portOpen, msgDrop, msgIn;

    assign portOpen = bankPort_q.bankSel == prfc_pkg::PORT_BANK &&
        bankPort_q.portSel == prfc_pkg::THIS_PORT;
    assign doWrite = awHeld_q && wHeld_q && !bValid_q;
    assign msgIn = rxMsg.valid;

    // Filtering decision
    always_comb begin
        msgDrop = filterCfg_q.typeFilterMask[rxMsg.messageType];
        if (filterCfg_q.versionFilterEnable &&
            filterMatch_q.versionMatch != prfc_pkg::VERSION_ANY &&
            rxMsg.version != filterMatch_q.versionMatch) begin
            msgDrop = 1'b1;
        end
        if (filterCfg_q.domainFilterEnable &&
            rxMsg.domain != filterMatch_q.domainMatch) begin
            msgDrop = 1'b1;
        end
        if (filterCfg_q.alternateFlagFilterEnable &&
            rxMsg.alternateFlag) begin
            msgDrop = 1'b1;
        end
    end

    always_comb begin
        verdict_d = '0;
        verdict_d.valid = msgIn;
        verdict_d.drop = msgIn && msgDrop;
        verdict_d.rxError = msgIn && msgDrop;
        verdict_d.correctionModify = msgIn && !msgDrop &&
            cfEnable_q[rxMsg.messageType];
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            verdict_q <= '0;
        end else begin
            verdict_q <= verdict_d;
        end
    end

    // Capture assembly
    always_comb begin
        capIn = '0;
        capIn.captureSeconds = rxMsg.ingressSeconds;
        capIn.captureNanoseconds = rxMsg.ingressNanoseconds;
        capIn.header.sourceIdentityCrc = crc12(rxMsg.sourceIdentity);
        capIn.header.capturedMessageType = rxMsg.messageType;
        capIn.header.capturedSequenceNumber = rxMsg.sequenceId;
    end

    assign capPush = msgIn && !msgDrop && tsEnable_q;
    assign capPop = doWrite && awAddr_q == prfc_pkg::OFF_CAPTURE_STATUS &&
        wStrb_q[prfc_pkg::POP_BIT / 8] && wData_q[prfc_pkg::POP_BIT];

    prfc_capture_buffer u_capture (
        .clk(core_clk),
        .rstn(rstn),
        .pushValid(capPush),
        .pushReady(),
        .pushData(capIn),
        .popValid(),
        .popReady(capPop),
        .popData(capHead),
        .count(capCount)
    );

    // Register writes and filtered counter
    always_comb begin
        bankPort_d = bankPort_q;
        filterCfg_d = filterCfg_q;
        filterMatch_d = filterMatch_q;
        cfEnable_d = cfEnable_q;
        tsEnable_d = tsEnable_q;
        filteredCnt_d = filteredCnt_q;
        if (doWrite) begin
            unique case (awAddr_q)
                prfc_pkg::OFF_BANK_PORT_SEL: begin
                    bankPort_d = mergeStrb(bankPort_q, wData_q, wStrb_q);
                    bankPort_d.rsvdHigh = '0;
                    bankPort_d.rsvdLow = 1'b0;
                end
                prfc_pkg::OFF_TS_CMD_CTL: begin
                    if (wStrb_q[0]) begin
                        tsEnable_d = wData_q[prfc_pkg::TS_ENABLE_BIT];
                    end
                end
                prfc_pkg::OFF_FILTER_MATCH: begin
                    filterMatch_d = mergeStrb(filterMatch_q, wData_q,
                        wStrb_q);
                    filterMatch_d.rsvd = '0;
                end
                prfc_pkg::OFF_CF_ENABLES: begin
                    if (portOpen) begin
                        cfEnable_d = 16'(mergeStrb({16'h0000, cfEnable_q},
                            wData_q, wStrb_q));
                    end
                end
                prfc_pkg::OFF_FILTER_CFG: begin
                    if (portOpen) begin
                        filterCfg_d = mergeStrb(filterCfg_q, wData_q,
                            wStrb_q);
                        filterCfg_d.rsvd = '0;
                    end
                end
                prfc_pkg::OFF_FILTERED_CNT: begin
                    if (portOpen) begin
                        filteredCnt_d = mergeStrb(filteredCnt_q, wData_q,
                            wStrb_q);
                    end
                end
                default: begin
                end
            endcase
        end
        // Increment lands on top of a same-cycle write, so no drop is lost
        if (verdict_d.drop && filteredCnt_d != prfc_pkg::COUNT_MAX) begin
            filteredCnt_d = filteredCnt_d + 32'h0000_0001;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            bankPort_q <= '0;
            filterCfg_q <= '{typeFilterMask: prfc_pkg::TYPE_FILTER_RST,
                default: '0};
            filterMatch_q <= '{versionMatch: prfc_pkg::VERSION_MATCH_RST,
                domainMatch: prfc_pkg::DOMAIN_MATCH_RST, default: '0};
            cfEnable_q <= prfc_pkg::CF_ENABLE_RST;
            tsEnable_q <= 1'b0;
            filteredCnt_q <= '0;
        end else begin
            bankPort_q <= bankPort_d;
            filterCfg_q <= filterCfg_d;
            filterMatch_q <= filterMatch_d;
            cfEnable_q <= cfEnable_d;
            tsEnable_q <= tsEnable_d;
            filteredCnt_q <= filteredCnt_d;
        end
    end

    // Bus slave
    always_comb begin
        awReady_d = awReady_q;
        awHeld_d = awHeld_q;
        awAddr_d = awAddr_q;
        wReady_d = wReady_q;
        wHeld_d = wHeld_q;
        wData_d = wData_q;
        wStrb_d = wStrb_q;
        bValid_d = bValid_q;
        bResp_d = bResp_q;
        arReady_d = arReady_q;
        rValid_d = rValid_q;
        rResp_d = rResp_q;
        rData_d = rData_q;
        if (s_axi_awvalid && awReady_q) begin
            awHeld_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wReady_q) begin
            wHeld_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb_d = s_axi_wstrb;
        end
        if (bValid_q && s_axi_bready) begin
            bValid_d = 1'b0;
        end
        if (doWrite) begin
            awHeld_d = 1'b0;
            wHeld_d = 1'b0;
            bValid_d = 1'b1;
            bResp_d = (isPortReg(awAddr_q) || isOwnReg(awAddr_q)) ?
                prfc_pkg::RESP_OKAY : prfc_pkg::RESP_SLVERR;
        end
        awReady_d = !awHeld_d;
        wReady_d = !wHeld_d;
        if (rValid_q && s_axi_rready) begin
            rValid_d = 1'b0;
            arReady_d = 1'b1;
        end
        if (s_axi_arvalid && arReady_q) begin
            arReady_d = 1'b0;
            rValid_d = 1'b1;
            rData_d = '0;
            rResp_d = prfc_pkg::RESP_OKAY;
            if (isPortReg(s_axi_araddr) && portOpen) begin
                unique case (s_axi_araddr)
                    prfc_pkg::OFF_CF_ENABLES: rData_d = {16'h0000, cfEnable_q};
                    prfc_pkg::OFF_FILTER_CFG: rData_d = filterCfg_q;
                    prfc_pkg::OFF_CAP_SECONDS: begin
                        rData_d = capHead.captureSeconds;
                    end
                    prfc_pkg::OFF_CAP_NANOS: begin
                        rData_d = {2'h0, capHead.captureNanoseconds};
                    end
                    prfc_pkg::OFF_CAP_HEADER: rData_d = capHead.header;
                    default: rData_d = filteredCnt_q;
                endcase
            end else if (s_axi_araddr == prfc_pkg::OFF_BANK_PORT_SEL) begin
                rData_d = bankPort_q;
            end else if (s_axi_araddr == prfc_pkg::OFF_TS_CMD_CTL) begin
                rData_d[prfc_pkg::TS_ENABLE_BIT] = tsEnable_q;
            end else if (s_axi_araddr == prfc_pkg::OFF_CAPTURE_STATUS) begin
                rData_d = {29'h0000_0000, capCount};
            end else if (s_axi_araddr == prfc_pkg::OFF_FILTER_MATCH) begin
                rData_d = filterMatch_q;
            end else if (!isPortReg(s_axi_araddr)) begin
                rResp_d = prfc_pkg::RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awReady_q <= 1'b1;
            awHeld_q <= 1'b0;
            awAddr_q <= '0;
            wReady_q <= 1'b1;
            wHeld_q <= 1'b0;
            wData_q <= '0;
            wStrb_q <= '0;
            bValid_q <= 1'b0;
            bResp_q <= prfc_pkg::RESP_OKAY;
            arReady_q <= 1'b1;
            rValid_q <= 1'b0;
            rResp_q <= prfc_pkg::RESP_OKAY;
            rData_q <= '0;
        end else begin
            awReady_q <= awReady_d;
            awHeld_q <= awHeld_d;
            awAddr_q <= awAddr_d;
            wReady_q <= wReady_d;
            wHeld_q <= wHeld_d;
            wData_q <= wData_d;
            wStrb_q <= wStrb_d;
            bValid_q <= bValid_d;
            bResp_q <= bResp_d;
            arReady_q <= arReady_d;
            rValid_q <= rValid_d;
            rResp_q <= rResp_d;
            rData_q <= rData_d;
        end
    end

    assign s_axi_awready = awReady_q;
    assign s_axi_wready = wReady_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_arready = arReady_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rresp = rResp_q;
    assign s_axi_rdata = rData_q;
    assign rxVerdict = verdict_q;
endmodule : prfc_rx_filter_capture

// >>> testbench/prfc_rx_filter_capture_asserts.sv
`timescale 1ns/100ps
module prfc_rx_filter_capture_asserts (
    input logic core_clk,
    input logic resetn,
    input logic s_axi_awvalid,
    input logic s_axi_awready,
    input logic s_axi_wvalid,
    input logic s_axi_wready,
    input logic [1:0] s_axi_bresp,
    input logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [prfc_pkg::ADDR_W-1:0] s_axi_araddr,
    input logic s_axi_arvalid,
    input logic s_axi_arready,
    input logic [prfc_pkg::DATA_W-1:0] s_axi_rdata,
    input logic s_axi_rvalid,
    input logic s_axi_rready,
    input prfc_pkg::prfc_rx_msg_t rxMsg,
    input prfc_pkg::prfc_verdict_t rxVerdict
);
    logic [prfc_pkg::ADDR_W-1:0] lastAr_q;
    logic [prfc_pkg::ADDR_W-1:0] lastAr_d;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    // Address of the read now being answered
    always_comb begin
        lastAr_d = lastAr_q;
        if (s_axi_arvalid && s_axi_arready) begin
            lastAr_d = s_axi_araddr;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            lastAr_q <= 12'h000;
        end else begin
            lastAr_q <= lastAr_d;
        end
    end

    a_verdict_next: assert property (rxMsg.valid |=> rxVerdict.valid)
        else $error("verdict missing after message");
    a_verdict_only: assert property (!rxMsg.valid |=> !rxVerdict.valid)
        else $error("verdict without message");
    a_error_is_drop: assert property (rxVerdict.valid |->
        rxVerdict.rxError == rxVerdict.drop)
        else $error("error flag differs from drop");
    a_drop_no_cf: assert property (rxVerdict.drop |->
        !rxVerdict.correctionModify)
        else $error("dropped message marked for correction");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |->
        ##[1:2] s_axi_rvalid)
        else $error("read not answered");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready &&
        s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
        else $error("write not answered");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed while waiting");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response changed while waiting");
    a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken during answer");
    a_nanos_rsvd: assert property (s_axi_rvalid &&
        lastAr_q == prfc_pkg::OFF_CAP_NANOS |-> s_axi_rdata[31:30] == 2'h0)
        else $error("nanoseconds top bits set");
endmodule : prfc_rx_filter_capture_asserts

bind prfc_rx_filter_capture prfc_rx_filter_capture_asserts
    prfc_rx_filter_capture_asserts_inst (.core_clk, .resetn,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready, .rxMsg, .rxVerdict);

// >>> testbench/tb_prfc_rx_filter_capture.sv
`timescale 1ns/100ps
module tb_prfc_rx_filter_capture;
    logic core_clk, resetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    prfc_pkg::prfc_rx_msg_t rxMsg;
    prfc_pkg::prfc_verdict_t rxVerdict;
    int mismatches, n_checks, cyc;

    prfc_rx_filter_capture prfc_rx_filter_capture_inst (.core_clk, .resetn,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .rxMsg, .rxVerdict);

    always #2 core_clk = ~core_clk;

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        rr = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask : rd

    // Checksum over the source identity, most significant bit first
    function automatic logic [11:0] crc12(input logic [79:0] x);
        logic [11:0] c;
        c = 12'h000;
        for (int i = 79; i >= 0; i--) begin
            c = {c[10:0], 1'b0} ^ ((c[11] ^ x[i]) ? prfc_pkg::CRC12_POLY : 12'h0);
        end
        return c;
    endfunction : crc12

    // One message in, verdict judged the cycle after
    task automatic msg(input logic [3:0] t, input logic [3:0] v,
        input logic [7:0] d, input logic a, input logic [15:0] s,
        input logic dr, input logic cm);
        @(posedge core_clk);
        rxMsg <= {1'b1, t, v, d, a, s, {5{s}}, s, ~s, 14'h0, s};
        @(posedge core_clk);
        rxMsg.valid <= 1'b0;
        @(negedge core_clk);
        chk({28'h0, rxVerdict}, {28'h0, 1'b1, dr, dr, cm});
    endtask : msg

    task automatic t_regs();
        rd(12'h164);
        chk(rv, 32'h0000_0000);
        rd(12'h100);
        chk({30'h0, rr}, {30'h0, prfc_pkg::RESP_SLVERR});
        wr(12'h000, 32'h0000_0011);
        rd(12'h164);
        chk(rv, 32'h0000_0000);
        wr(12'h000, 32'h0000_0001);
        rd(12'h164);
        chk(rv, 32'h0000_000F);
        rd(12'h168);
        chk(rv, 32'h0000_0000);
        wr(12'h16C, 32'hFFFF_FFFF);
        chk({30'h0, rr}, 32'h0000_0000);
        rd(12'h16C);
        chk(rv, 32'h0000_0000);
        rd(12'h170);
        chk(rv, 32'h0000_0000);
        rd(12'h174);
        chk(rv, 32'h0000_0000);
    endtask : t_regs

    task automatic t_correct();
        for (int t = 0; t < 16; t++) begin
            msg(4'(t), 4'h2, 8'h00, 1'b0, 16'(t), 1'b0, 1'(t < 4));
        end
        wr(12'h164, 32'h0000_8000);
        msg(4'hF, 4'h2, 8'h00, 1'b0, 16'h0001, 1'b0, 1'b1);
        msg(4'h0, 4'h2, 8'h00, 1'b0, 16'h0002, 1'b0, 1'b0);
        wr(12'h164, 32'h0000_000F);
    endtask : t_correct

    task automatic t_type();
        wr(12'h168, 32'h0000_AAAA);
        for (int t = 0; t < 16; t++) begin
            msg(4'(t), 4'h2, 8'h00, 1'b0, 16'(t), 1'(t % 2),
                1'(t < 4 && t % 2 == 0));
        end
        rd(12'h18C);
        chk(rv, 32'h0000_0008);
    endtask : t_type

    task automatic t_fields();
        wr(12'h168, 32'h0001_0000);
        msg(4'h0, 4'h2, 8'h00, 1'b0, 16'h0010, 1'b0, 1'b1);
        msg(4'h0, 4'h1, 8'h00, 1'b0, 16'h0011, 1'b1, 1'b0);
        wr(12'h168, 32'h0002_0000);
        msg(4'h0, 4'h2, 8'h00, 1'b0, 16'h0012, 1'b0, 1'b1);
        msg(4'h0, 4'h2, 8'h05, 1'b0, 16'h0013, 1'b1, 1'b0);
        wr(12'h168, 32'h0004_0000);
        msg(4'h0, 4'h2, 8'h00, 1'b0, 16'h0014, 1'b0, 1'b1);
        msg(4'h0, 4'h2, 8'h00, 1'b1, 16'h0015, 1'b1, 1'b0);
        wr(12'h168, 32'h0000_0000);
        msg(4'h0, 4'h1, 8'h05, 1'b1, 16'h0016, 1'b0, 1'b1);
    endtask : t_fields

    task automatic t_cap();
        logic [15:0] s;
        wr(12'h004, 32'h0000_0001);
        for (int i = 0; i < 5; i++) begin
            msg(4'(i), 4'h2, 8'h00, 1'b0, 16'(16'hA5C0 + i), 1'b0, 1'(i < 4));
        end
        for (int i = 0; i < 4; i++) begin
            s = 16'(16'hA5C0 + i);
            rd(12'h008);
            chk({29'h0, rv[2:0]}, 32'(4 - i));
            rd(12'h16C);
            chk(rv, {s, ~s});
            rd(12'h170);
            chk(rv, {16'h0, s});
            rd(12'h174);
            chk(rv, {crc12({5{s}}), 4'(i), s});
            wr(12'h008, 32'h0000_0100);
        end
        rd(12'h008);
        chk({29'h0, rv[2:0]}, 32'h0000_0000);
    endtask : t_cap

    initial begin
        core_clk = 1'b0;
        resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
        {s_axi_arvalid, s_axi_rready} = 2'h0;
        s_axi_awaddr = 12'h000;
        s_axi_araddr = 12'h000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        rxMsg = '0;
        mismatches = 0;
        n_checks = 0;
        cyc = 0;
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge core_clk);
        t_regs();
        t_correct();
        t_type();
        t_fields();
        t_cap();
        end_of_test();
    end
endmodule : tb_prfc_rx_filter_capture
